// >>> verilog/two_wire_unit.sv
// two-wire unit: apb registers, master transmit engine, own address match
`timescale 1ns/1ps
`include "tw_slave_cfg.svh"
module two_wire_unit
   import tw_slave_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output wire logic        pready,
   output wire logic        pslverr,
   input  wire logic        global_irq_enable,
   output wire logic        irq,
   input  wire logic        scl_in,
   output wire logic        scl_out,
   output wire logic        scl_oe,
   input  wire logic        sda_in,
   output wire logic        sda_out,
   output wire logic        sda_oe
);
   localparam logic [9:0] HALF = 10'(`SCL_HALF_CYC - 1);

   function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] oar);
      addr_hit = (rx[7:1] == oar[7:1]) || (rx[7:1] == 7'h00 && oar[0]);
   endfunction : addr_hit

   tw_state_t   state;
   logic [7:0]  own_slave_address;
   logic [7:0]  bus_data_register;
   logic [4:0]  status_code_field;
   logic [4:0]  pend_code;
   logic [1:0]  prescale;
   logic        flag, ack_en, start_request, stop_request, wcol, enable, completion_irq_enable;
   logic        scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
   logic        busy, ph, addr_phase, mst, gc_seen, scl_drv, sda_drv;
   logic [9:0]  cnt;
   logic [3:0]  bitn;
   logic [7:0]  shreg;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire wr       = psel & penable & pwrite;
   wire sel_ctrl = paddr == `OFS_CTRL;
   wire sel_stat = paddr == `OFS_STAT;
   wire sel_data = paddr == `OFS_DATA;
   wire sel_addr = paddr == `OFS_ADDR;
   wire hit      = sel_ctrl | sel_stat | sel_data | sel_addr;
   wire wr_ctrl  = wr & sel_ctrl;
   wire wr_data  = wr & sel_data;
   wire clr_flag = wr_ctrl & pwdata[`CB_FLAG];
   wire [7:0] ctrl_rd = {flag, ack_en, start_request, stop_request, wcol, enable, 1'b0,
                         completion_irq_enable};
   wire [7:0] stat_rd = {status_code_field, 1'b0, prescale};
   wire [7:0] rd_mux  = sel_ctrl ? ctrl_rd : sel_stat ? stat_rd :
                        sel_data ? bus_data_register : sel_addr ? own_slave_address : 8'h00;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // read data captured in the setup cycle so the access phase needs no wait
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) prdata <= 32'h0000_0000;
      else if (psel & ~penable) prdata <= {24'h00_0000, rd_mux};
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and bus condition detection
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f;
      else {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <=
         {scl_in, scl_m, scl_s, sda_in, sda_m, sda_s};
   end
   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire start_det = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) busy <= 1'b0;
      else busy <= enable & (start_det | (busy & ~stop_det));
   end

   ////////////////////////////////////////////////////////////////////////////
   // events
   wire stretch  = (state == ST_BIT) & ph & ~scl_s;
   wire tick     = (cnt == 10'h000) & ~stretch;
   wire rx_match = addr_hit(shreg, own_slave_address);
   wire ev_start = (state == ST_START) & ph & tick;
   wire ev_byte  = (state == ST_BIT) & ph & tick & (bitn == 4'h8);
   wire ev_stop  = (state == ST_STOP) & ph & tick;
   wire ev_saddr = (state == ST_SACK) & scl_fall;
   wire set_flag = ev_start | ev_byte | ev_saddr;
   wire acked    = ~sda_s;
   wire [4:0] set_code = ev_start ? `SC_START :
                         ev_saddr ? (gc_seen ? `SC_GEN_CALL : `SC_OWN_ADDR) :
                         addr_phase ? (acked ? `SC_SLA_ACK : `SC_SLA_NACK) :
                         (acked ? `SC_DAT_ACK : `SC_DAT_NACK);

   ////////////////////////////////////////////////////////////////////////////
   // completion flag and status; a hardware set wins over a software clear
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag      <= 1'b0;
         pend_code <= `SC_NONE;
      end else begin
         flag <= set_flag | (flag & ~clr_flag);
         if (set_flag) pend_code <= set_code;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) status_code_field <= `SC_NONE;
      else status_code_field <= flag ? pend_code : `SC_NONE;
   end

   assign irq = flag & completion_irq_enable & global_irq_enable;

   ////////////////////////////////////////////////////////////////////////////
   // control, address and data registers
   wire leave_hold = (state == ST_HOLD) & ~flag;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {ack_en, start_request, stop_request, enable, completion_irq_enable} <= 5'h00;
         prescale <= 2'h0;
         own_slave_address <= `RST_ADDR;
      end else begin
         if (ev_start) start_request <= 1'b0;
         if (ev_stop | (leave_hold & ~mst)) stop_request <= 1'b0;
         if (wr_ctrl) begin
            ack_en                <= pwdata[`CB_ACKEN];
            start_request         <= pwdata[`CB_START];
            stop_request          <= pwdata[`CB_STOP];
            enable                <= pwdata[`CB_EN];
            completion_irq_enable <= pwdata[`CB_IE];
         end
         if (wr & sel_stat) prescale <= pwdata[1:0];
         if (wr & sel_addr) own_slave_address <= pwdata[7:0];
      end
   end

   // data is only writable while the completion flag is set; otherwise a collision
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_data_register <= `RST_DATA;
         wcol              <= 1'b0;
      end else begin
         if (wr_data) wcol <= ~flag;
         if (wr_data & flag) bus_data_register <= pwdata[7:0];
         else if (ev_saddr) bus_data_register <= shreg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus engine
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         {ph, addr_phase, mst, gc_seen, scl_drv, sda_drv} <= 6'h00;
         cnt   <= 10'h000;
         bitn  <= 4'h0;
         shreg <= 8'h00;
      end else begin
         if (cnt != 10'h000 && !stretch) cnt <= cnt - 10'h001;
         if (!enable) begin
            state <= ST_IDLE;
            {mst, scl_drv, sda_drv} <= 3'h0;
         end else begin
            case (state)
               ST_IDLE: begin
                  {scl_drv, sda_drv} <= 2'h0;
                  if (start_request && !busy && !flag) begin
                     state <= ST_START;
                     ph    <= 1'b0;
                     cnt   <= HALF;
                  end else if (start_det) begin
                     state <= ST_SLV;
                     bitn  <= 4'h0;
                  end
               end
               ST_START: if (tick) begin
                  cnt <= HALF;
                  if (!ph) begin
                     ph      <= 1'b1;
                     sda_drv <= 1'b1;
                  end else begin
                     state      <= ST_HOLD;
                     scl_drv    <= 1'b1;
                     mst        <= 1'b1;
                     addr_phase <= 1'b1;
                  end
               end
               ST_HOLD: begin
                  scl_drv <= 1'b1;
                  if (!flag) begin
                     cnt <= HALF;
                     ph  <= 1'b0;
                     if (!mst) begin
                        state   <= ST_IDLE;
                        scl_drv <= 1'b0;
                     end else if (stop_request) begin
                        state   <= ST_STOP;
                        sda_drv <= 1'b1;
                     end else if (start_request) begin
                        state   <= ST_START;
                        scl_drv <= 1'b0;
                        sda_drv <= 1'b0;
                     end else begin
                        state   <= ST_BIT;
                        shreg   <= bus_data_register;
                        sda_drv <= ~bus_data_register[7];
                        bitn    <= 4'h0;
                     end
                  end
               end
               ST_BIT: if (tick) begin
                  cnt <= HALF;
                  if (!ph) begin
                     ph      <= 1'b1;
                     scl_drv <= 1'b0;
                  end else if (bitn == 4'h8) begin
                     // cleared only after the event, so the first byte reports address codes
                     state      <= ST_HOLD;
                     scl_drv    <= 1'b1;
                     addr_phase <= 1'b0;
                  end else begin
                     ph         <= 1'b0;
                     scl_drv    <= 1'b1;
                     bitn       <= bitn + 4'h1;
                     shreg      <= {shreg[6:0], 1'b0};
                     sda_drv    <= (bitn == 4'h7) ? 1'b0 : ~shreg[6];
                  end
               end
               ST_STOP: if (tick) begin
                  cnt <= HALF;
                  if (!ph) begin
                     ph      <= 1'b1;
                     scl_drv <= 1'b0;
                  end else begin
                     state   <= ST_IDLE;
                     sda_drv <= 1'b0;
                     mst     <= 1'b0;
                  end
               end
               ST_SLV: begin
                  if (stop_det) state <= ST_IDLE;
                  else if (scl_rise && bitn != 4'h8) begin
                     shreg <= {shreg[6:0], sda_s};
                     bitn  <= bitn + 4'h1;
                  end else if (scl_fall && bitn == 4'h8) begin
                     // no acknowledge when not addressed, so other slaves keep the bus
                     if (rx_match && ack_en) begin
                        state   <= ST_SACK;
                        sda_drv <= 1'b1;
                        gc_seen <= shreg[7:1] == 7'h00;
                     end else state <= ST_IDLE;
                  end
               end
               ST_SACK: if (scl_fall) begin
                  state   <= ST_HOLD;
                  sda_drv <= 1'b0;
                  scl_drv <= 1'b1;
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe  = scl_drv;
   assign sda_oe  = sda_drv;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_status_follows_flag: assert property ($rose(flag) |=>
      status_code_field == pend_code)
      else $error("status not loaded one cycle after flag");
   a_status_idle_code: assert property (!flag |=> status_code_field == `SC_NONE)
      else $error("status not idle code while flag clear");
   a_irq_gated: assert property (irq |->
      flag && completion_irq_enable && global_irq_enable)
      else $error("interrupt without all enables");
   a_irq_when_enabled: assert property (flag && completion_irq_enable &&
      global_irq_enable |-> irq)
      else $error("interrupt missing with all enables set");
   a_flag_clear_one: assert property (flag && clr_flag && !set_flag |=> !flag)
      else $error("flag not cleared by writing one");
   a_flag_keep_zero: assert property (flag && !clr_flag |=> flag)
      else $error("flag lost without a clearing write");
   a_hold_scl_low: assert property (flag && $past(flag) |->
      scl_oe && state == ST_HOLD)
      else $error("clock released while flag set");
   a_start_waits_free: assert property (state == ST_IDLE && (busy || flag) |=>
      state != ST_START)
      else $error("start issued on a busy bus or with flag set");
   a_start_event: assert property (ev_start |=>
      flag && pend_code == `SC_START && !start_request)
      else $error("start not reported");
   a_byte_from_data: assert property (leave_hold && mst && enable &&
      !stop_request && !start_request |=> shreg == $past(bus_data_register))
      else $error("byte not taken from the data register");
   a_addr_event: assert property (ev_byte && addr_phase |=> flag &&
      (pend_code == `SC_SLA_ACK || pend_code == `SC_SLA_NACK))
      else $error("address packet not reported");
   a_data_event: assert property (ev_byte && !addr_phase |=> flag &&
      (pend_code == `SC_DAT_ACK || pend_code == `SC_DAT_NACK))
      else $error("data packet not reported");
   a_stop_quiet: assert property (ev_stop && !wr_ctrl |=>
      !flag && !stop_request ##1 !flag)
      else $error("flag or request left after stop");
   a_match_flag: assert property (ev_saddr |=>
      flag && (pend_code == `SC_OWN_ADDR || pend_code == `SC_GEN_CALL))
      else $error("address match not flagged");
   a_gc_needs_enable: assert property (ev_saddr && gc_seen &&
      own_slave_address[7:1] != 7'h00 |-> own_slave_address[0])
      else $error("general call answered while disabled");
endmodule : two_wire_unit

// >>> verilog/tw_slave_cfg.svh
// offsets, field positions, reset values and timing counts of the two-wire unit
`ifndef TW_SLAVE_CFG_SVH
`define TW_SLAVE_CFG_SVH
`define OFS_CTRL      8'h00
`define OFS_STAT      8'h04
`define OFS_DATA      8'h08
`define OFS_ADDR      8'h0c
`define CB_FLAG       7
`define CB_ACKEN      6
`define CB_START      5
`define CB_STOP       4
`define CB_WC         3
`define CB_EN         2
`define CB_IE         0
`define RST_ADDR      8'h00
`define RST_DATA      8'hff
`define SC_START      5'h01
`define SC_SLA_ACK    5'h03
`define SC_SLA_NACK   5'h04
`define SC_DAT_ACK    5'h05
`define SC_DAT_NACK   5'h06
`define SC_OWN_ADDR   5'h0c
`define SC_GEN_CALL   5'h0e
`define SC_NONE       5'h1f
`define CLK_MHZ       100
`define SCL_HALF_NS   5000
`define SCL_HALF_CYC  (`SCL_HALF_NS * `CLK_MHZ / 1000)
`endif

// >>> verilog/tw_slave_pkg.sv
// types of the two-wire unit
package tw_slave_pkg;
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b0000001,
      ST_START = 7'b0000010,
      ST_BIT   = 7'b0000100,
      ST_HOLD  = 7'b0001000,
      ST_STOP  = 7'b0010000,
      ST_SLV   = 7'b0100000,
      ST_SACK  = 7'b1000000
   } tw_state_t;
endpackage : tw_slave_pkg

// >>> verif/tw_bus_partner.sv
// far-side model: bus slave that acknowledges its own address, plus a master for address packets
`timescale 1ns/1ps
module tw_bus_partner #(
   parameter logic [6:0] OWN_ADDR = 7'h52
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       ack_en,
   output logic            scl_pull,
   output logic            sda_pull,
   output logic [7:0]      last_byte,
   output logic [3:0]      bit_cnt
);
   localparam time T_Q = 20;
   logic [7:0] shift_in;
   logic       first;
   logic       addressed;
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      last_byte = 8'h00;
      bit_cnt = 4'h0;
      first = 1'b0;
      addressed = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // a start resets the bit count; a stop only adds a stray count, undone by the next start
   // let a clock fall in the same step settle first: a data change at that edge is no start
   always @(negedge sda) begin
      #1;
      if (scl === 1'b1 && sda === 1'b0) begin
         bit_cnt = 4'h0;
         first = 1'b1;
      end
   end
   always @(posedge scl) begin
      shift_in = {shift_in[6:0], sda};
      bit_cnt = bit_cnt + 4'h1;
   end
   always @(negedge scl) begin
      if (bit_cnt == 4'h8) begin
         last_byte = shift_in;
         if (first) addressed = (shift_in[7:1] == OWN_ADDR);
         first = 1'b0;
         if (addressed && ack_en) sda_pull = 1'b1;
      end else if (bit_cnt == 4'h9) begin
         sda_pull = 1'b0;
         bit_cnt = 4'h0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // master side: 80 ns bit period; waits while the other party stretches the clock
   task automatic send_addr(input logic [7:0] b, output logic ack_n);
      logic [8:0] bits;
      bits = {b, 1'b1};
      sda_pull = 1'b1;
      #T_Q;
      for (int i = 8; i >= 0; i--) begin
         scl_pull = 1'b1;
         #T_Q;
         sda_pull = ~bits[i];
         #T_Q;
         scl_pull = 1'b0;
         wait (scl === 1'b1);
         #T_Q;
         if (i == 0) ack_n = sda;
         #T_Q;
      end
      scl_pull = 1'b1;
      #(2 * T_Q);
   endtask : send_addr
   task automatic stop_bus;
      sda_pull = 1'b1;
      #T_Q;
      scl_pull = 1'b0;
      wait (scl === 1'b1);
      #T_Q;
      sda_pull = 1'b0;
      #T_Q;
   endtask : stop_bus
endmodule : tw_bus_partner

// >>> verif/two_wire_unit_tb_top.sv
// testbench: apb master and test sequence of the two-wire unit
`timescale 1ns/1ps
`include "tw_slave_cfg.svh"
module two_wire_unit_tb_top;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        global_irq_enable = 1'b0;
   logic        ack_en = 1'b1;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, scl_out, scl_oe, sda_out, sda_oe;
   logic        m_scl, m_sda, ack_n, rd_err;
   logic [7:0]  rd_data, p_byte;
   logic [3:0]  p_cnt;
   int          err_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   // open-drain lines with pull-ups: low while anyone pulls
   wire         scl = (scl_oe ? scl_out : 1'b1) & ~m_scl;
   wire         sda = (sda_oe ? sda_out : 1'b1) & ~m_sda;
   logic [7:0]  ofs [4] = '{`OFS_CTRL, `OFS_STAT, `OFS_DATA, `OFS_ADDR};
   logic [7:0]  rst_v [4] = '{8'h00, {`SC_NONE, 3'b000}, `RST_DATA, `RST_ADDR};
   logic [7:0]  own_v [4] = '{8'h5b, 8'h5b, 8'h5a, 8'h5b};
   logic [7:0]  sent_v [4] = '{8'h5a, 8'h00, 8'h00, 8'h5c};
   logic [7:0]  code_v [4] = '{{`SC_OWN_ADDR, 3'b000}, {`SC_GEN_CALL, 3'b000}, 8'h00, 8'h00};
   logic        hit_v [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   always #5 ref_clk = ~ref_clk;
   two_wire_unit i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .global_irq_enable(global_irq_enable), .irq(irq), .scl_in(scl),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
   tw_bus_partner i_partner (.scl(scl), .sda(sda), .ack_en(ack_en), .scl_pull(m_scl),
      .sda_pull(m_sda), .last_byte(p_byte), .bit_cnt(p_cnt));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd_data = prdata[7:0];
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
   endtask : rd
   task automatic wait_flag;
      rd(`OFS_CTRL);
      while (rd_data[`CB_FLAG] !== 1'b1) rd(`OFS_CTRL);
   endtask : wait_flag
   task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk_reg
   task automatic chk_bit(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////////
   // a full master byte is about 9000 cycles; the whole sequence stays near 32000
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 70000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(ofs[i]);
         chk_reg("reset value", rst_v[i], rd_data);
      end
      wr(`OFS_STAT, 8'hff);
      rd(`OFS_STAT);
      chk_reg("status prescaler", {`SC_NONE, 3'b011}, rd_data);
      wr(`OFS_STAT, 8'h00);
      rd(8'h10);
      chk_bit("unmapped error", 1'b1, rd_err);
      wr(`OFS_DATA, 8'h11);
      rd(`OFS_CTRL);
      chk_bit("write collision", 1'b1, rd_data[`CB_WC]);
      wr(`OFS_ADDR, 8'h5b);
      wr(`OFS_CTRL, 8'ha5);
      wait_flag;
      rd(`OFS_STAT);
      chk_reg("start status", {`SC_START, 3'b000}, rd_data);
      rd(`OFS_CTRL);
      chk_bit("start request", 1'b0, rd_data[`CB_START]);
      chk_bit("irq global off", 1'b0, irq);
      global_irq_enable <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk_bit("irq", 1'b1, irq);
      wr(`OFS_CTRL, 8'h05);
      repeat (700) @(posedge ref_clk);
      rd(`OFS_CTRL);
      chk_bit("flag kept", 1'b1, rd_data[`CB_FLAG]);
      chk_bit("scl held", 1'b0, scl);
      chk_reg("bits moved", 8'h00, {4'h0, p_cnt});
      wr(`OFS_DATA, 8'ha4);
      rd(`OFS_CTRL);
      chk_bit("collision cleared", 1'b0, rd_data[`CB_WC]);
      wr(`OFS_CTRL, 8'h85);
      wait_flag;
      rd(`OFS_STAT);
      chk_reg("address status", {`SC_SLA_ACK, 3'b000}, rd_data);
      chk_reg("address on wire", 8'ha4, p_byte);
      wr(`OFS_DATA, 8'h3c);
      wr(`OFS_CTRL, 8'h85);
      wait_flag;
      rd(`OFS_STAT);
      chk_reg("data status", {`SC_DAT_ACK, 3'b000}, rd_data);
      chk_reg("data on wire", 8'h3c, p_byte);
      ack_en <= 1'b0;
      wr(`OFS_DATA, 8'hc3);
      wr(`OFS_CTRL, 8'h85);
      wait_flag;
      rd(`OFS_STAT);
      chk_reg("data nack status", {`SC_DAT_NACK, 3'b000}, rd_data);
      wr(`OFS_CTRL, 8'h95);
      rd(`OFS_CTRL);
      while (rd_data[`CB_STOP] !== 1'b0) rd(`OFS_CTRL);
      repeat (1200) @(posedge ref_clk);
      rd(`OFS_CTRL);
      chk_bit("flag after stop", 1'b0, rd_data[`CB_FLAG]);
      chk_bit("irq after stop", 1'b0, irq);
      chk_bit("sda after stop", 1'b1, sda);
      rd(`OFS_STAT);
      chk_reg("idle status", {`SC_NONE, 3'b000}, rd_data);
      wr(`OFS_CTRL, 8'h45);
      for (int k = 0; k < 4; k++) begin
         wr(`OFS_ADDR, own_v[k]);
         i_partner.send_addr(sent_v[k], ack_n);
         chk_bit("slave ack", ~hit_v[k], ack_n);
         if (hit_v[k]) begin
            wait_flag;
            chk_bit("match irq", 1'b1, irq);
            rd(`OFS_STAT);
            chk_reg("slave status", code_v[k], rd_data);
            wr(`OFS_CTRL, 8'hc5);
         end else begin
            rd(`OFS_CTRL);
            chk_bit("no match flag", 1'b0, rd_data[`CB_FLAG]);
         end
         i_partner.stop_bus();
      end
      final_report();
   end
endmodule : two_wire_unit_tb_top
